//--- tb/test_gpss_cfg_regs.sv
/*
  Self-checking bench for gpss_cfg_regs: corner and random config cycles.
  Assumes the design package, header and modules are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module test_gpss_cfg_regs;
  logic        clock     = 1'b0;
  logic        rst_n     = 1'b0;
  logic        cfg_req   = 1'b0;
  logic        cfg_write = 1'b0;
  logic [7:0]  cfg_addr  = 8'h00;
  logic [3:0]  cfg_be    = 4'h0;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [31:0] rd;
  wire  logic        cfg_ack_r;
  wire  logic [31:0] cfg_rdata_r;
  wire  logic        smi_req_r;
  wire  logic [1:0]  power_state_r;
  wire  logic        gfx_reinit_r;
  int          err_count   = 0;
  int          check_count = 0;
  int          cycles      = 0;
  int          seed        = 68;
  logic [15:0] smi_m       = 16'h0000;
  logic [1:0]  ps_m        = 2'h0;

  always #5 clock = ~clock;

  gpss_cfg_regs i_gpss_cfg_regs (
    .clock(clock), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack_r(cfg_ack_r), .cfg_rdata_r(cfg_rdata_r), .smi_req_r(smi_req_r),
    .power_state_r(power_state_r), .gfx_reinit_r(gfx_reinit_r)
  );

  // ****************************************************************
  // Expectation and checking
  // ****************************************************************
  function automatic logic [15:0] smi_next(logic [15:0] o, logic [3:0] be, logic [31:0] d);
    return {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
  endfunction

  // Only D0 and D3 are accepted; other codes leave the state alone
  function automatic logic [1:0] ps_next(logic [1:0] o, logic [3:0] be, logic [31:0] d);
    return (be[0] && (d[1:0] == 2'h0 || d[1:0] == 2'h3)) ? d[1:0] : o;
  endfunction

  function automatic logic [31:0] rd_exp(logic [7:0] a);
    return (a[7:2] == 6'h38) ? {16'h0000, smi_m} : (a[7:2] == 6'h35) ? {30'h0, ps_m} : 32'h0;
  endfunction

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%08h exp=%08h", $time, got, exp);
    end
  endtask

  // ****************************************************************
  // Config cycles
  // ****************************************************************
  // Idle cycle after each access keeps strobes from toggling twice in a step
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    cfg_req   = 1'b1;
    cfg_write = w;
    cfg_addr  = a;
    cfg_be    = be;
    cfg_wdata = d;
    @(posedge clock);
    #1;
    cfg_req = 1'b0;
    chk({31'h0, cfg_ack_r}, 32'h1);
    rd = cfg_rdata_r;
    @(posedge clock);
    #1;
    chk({31'h0, cfg_ack_r}, 32'h0);
  endtask

  task automatic rdc(input logic [7:0] a);
    acc(1'b0, a, 4'hF, 32'h0);
    chk(rd, rd_exp(a));
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [1:0] old;
    old = ps_m;
    acc(1'b1, a, be, d);
    if (a[7:2] == 6'h38) smi_m = smi_next(smi_m, be, d);
    if (a[7:2] == 6'h35) ps_m = ps_next(ps_m, be, d);
    chk({31'h0, smi_req_r}, {31'h0, smi_m[0]});
    chk({30'h0, power_state_r}, {30'h0, ps_m});
    chk({31'h0, gfx_reinit_r}, {31'h0, old == 2'h3 && ps_m == 2'h0});
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      test_done;
    end
  end

  initial begin
    logic [31:0] r;
    logic [7:0]  a;
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
    rdc(8'hD4);
    rdc(8'hE0);
    wr(8'hD4, 4'hF, 32'hFFFF_FFFF);
    rdc(8'hD4);
    wr(8'hD4, 4'h1, 32'h0000_0001);
    wr(8'hD4, 4'h1, 32'h0000_0002);
    wr(8'hD4, 4'hE, 32'h0000_0000);
    wr(8'hD4, 4'h1, 32'h0000_0000);
    wr(8'hE0, 4'h1, 32'h0000_0001);
    wr(8'hE0, 4'h2, 32'h0000_FE00);
    rdc(8'hE1);
    wr(8'hE0, 4'h1, 32'h0000_00A4);
    rdc(8'h40);
    for (int i = 0; i < 200; i++) begin
      r = $random(seed);
      case (r[9:8])
        2'h0: a = 8'hD4;
        2'h1: a = 8'hE0;
        2'h2: a = 8'hE3;
        default: a = r[7:0];
      endcase
      if (r[10]) begin
        wr(a, r[14:11], $random(seed));
      end else begin
        rdc(a);
      end
    end
    test_done;
  end
endmodule

`default_nettype wire

//--- verilog/gpss_cfg_regs.sv
/*
  Config-space register pair of the integrated graphics function: power
  control/status and software SMI request, with read mux and SMI output.
  Assumes a config cycle port on the same clock: one-cycle request, one-cycle ack.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gpss_regs.svh"

module gpss_cfg_regs #(
  parameter int unsigned REINIT_ON_D0 = 1
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Config cycle request
  input  wire logic        cfg_req,
  input  wire logic        cfg_write,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  // Config cycle answer
  output logic             cfg_ack_r,
  output logic [31:0]      cfg_rdata_r,
  // Block outputs
  output logic             smi_req_r,
  output logic [1:0]       power_state_r,
  output logic             gfx_reinit_r
);

  localparam logic [7:0]  PWR_CS_OFF = `GPSS_PWR_CS_OFF;
  localparam logic [7:0]  SMI_OFF    = `GPSS_SMI_OFF;
  localparam logic [15:0] SMI_RESET  = `GPSS_SMI_RESET;
  localparam logic [31:0] RDATA_ZERO = `GPSS_RDATA_RESET;

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic hit_pwr;
  logic hit_smi;
  logic wr_pwr;
  logic wr_smi_lo;
  logic wr_smi_hi;

  assign hit_pwr   = cfg_addr[7:2] == PWR_CS_OFF[7:2];
  assign hit_smi   = cfg_addr[7:2] == SMI_OFF[7:2];
  assign wr_pwr    = cfg_req && cfg_write && hit_pwr && cfg_be[0];
  assign wr_smi_lo = cfg_req && cfg_write && hit_smi && cfg_be[0];
  assign wr_smi_hi = cfg_req && cfg_write && hit_smi && cfg_be[1];

  // ****************************************************************
  // Power control/status
  // ****************************************************************
  gpss_pkg::gpss_pstate_e pstate;
  logic                   reinit;

  gpss_pm_state #(
    .REINIT_ON_D0 (REINIT_ON_D0)
  ) u_pm_state (
    .clock    (clock),
    .rst_n    (rst_n),
    .wr_en    (wr_pwr),
    .wr_code  (cfg_wdata[1:0]),
    .state_r  (pstate),
    .reinit_r (reinit)
  );

  // Upper byte writes land nowhere: wake bits and reserved bits are fixed
  logic [15:0] pwr_view;
  assign pwr_view = {1'b0, `GPSS_RSVD_ZERO, 1'b0, `GPSS_RSVD_ZERO, pstate};

  // Registered copies so every output comes from a flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_state_r <= `GPSS_PS_D0;
      gfx_reinit_r  <= 1'b0;
    end else begin
      power_state_r <= pstate;
      gfx_reinit_r  <= reinit;
    end
  end

  // ****************************************************************
  // Software SMI request
  // ****************************************************************
  // Flag byte and scratch byte live in separate flops so that each
  // byte lane has exactly one writing process
  logic [7:0]  smi_lo_r;
  logic [7:0]  smi_hi_r;
  logic [15:0] smi_view;

  assign smi_view = {smi_hi_r, smi_lo_r};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      smi_lo_r <= SMI_RESET[7:0];
    end else if (wr_smi_lo) begin
      // Event bit has no hardware setter, so only software moves it
      smi_lo_r <= cfg_wdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      smi_hi_r <= SMI_RESET[15:8];
    end else if (wr_smi_hi) begin
      smi_hi_r <= cfg_wdata[15:8];
    end
  end

  // Request follows the stored bit one cycle later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      smi_req_r <= 1'b0;
    end else begin
      smi_req_r <= smi_lo_r[`GPSS_SMI_EVT_BIT];
    end
  end

  // ****************************************************************
  // Answer
  // ****************************************************************
  // Unmapped offsets read zero and writes to them complete silently
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ack_r   <= 1'b0;
      cfg_rdata_r <= `GPSS_RDATA_RESET;
    end else begin
      cfg_ack_r <= cfg_req;
      if (cfg_req && !cfg_write) begin
        if (hit_pwr) begin
          cfg_rdata_r <= {16'h0000, pwr_view};
        end else if (hit_smi) begin
          cfg_rdata_r <= {16'h0000, smi_view};
        end else begin
          cfg_rdata_r <= `GPSS_RDATA_RESET;
        end
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_rd_pwr;
    cfg_req && !cfg_write && hit_pwr;
  endsequence

  sequence s_set_event;
    wr_smi_lo && cfg_wdata[`GPSS_SMI_EVT_BIT];
  endsequence

  sequence s_clear_event;
    wr_smi_lo && !cfg_wdata[`GPSS_SMI_EVT_BIT];
  endsequence

  sequence s_leave_d3;
    wr_pwr && pstate == gpss_pkg::GPSS_D3 && cfg_wdata[1:0] == `GPSS_PS_D0;
  endsequence

  // Wake enable written as one, then read back with one idle cycle between
  sequence s_wake_en_probe;
    wr_pwr && cfg_wdata[`GPSS_WAKE_EN_BIT] ##2 s_rd_pwr;
  endsequence

  a_wake_status_zero: assert property (
    s_rd_pwr |=> cfg_ack_r && !cfg_rdata_r[`GPSS_WAKE_STS_BIT])
    else $error("wake status bit read as one");
  a_wake_enable_zero: assert property (
    s_wake_en_probe |=> !cfg_rdata_r[`GPSS_WAKE_EN_BIT])
    else $error("wake enable bit became settable");
  a_pstate_readback: assert property (
    s_rd_pwr |=> cfg_rdata_r[1:0] == $past(pstate))
    else $error("power state readback mismatch");
  a_reserved_zero: assert property (
    s_rd_pwr |=> cfg_rdata_r[14:9] == `GPSS_RSVD_ZERO && cfg_rdata_r[7:2] == `GPSS_RSVD_ZERO)
    else $error("reserved power bits not zero");
  a_unsup_write_ack: assert property (
    wr_pwr && (cfg_wdata[1:0] == `GPSS_PS_D1 || cfg_wdata[1:0] == `GPSS_PS_D2)
      |=> cfg_ack_r ##1 power_state_r == $past(pstate, 2))
    else $error("unsupported write not completed or state moved");
  a_d3_entry: assert property (
    wr_pwr && cfg_wdata[1:0] == `GPSS_PS_D3 |=> ##1 power_state_r == `GPSS_PS_D3)
    else $error("power state output did not reach D3");
  a_reinit_out: assert property (
    s_leave_d3 |=> ##1 gfx_reinit_r == (REINIT_ON_D0 != 0) && power_state_r == `GPSS_PS_D0)
    else $error("reinit output wrong on D3 exit");
  a_ack_follows: assert property (
    cfg_req |=> cfg_ack_r)
    else $error("config request not answered");
  a_ack_single: assert property (
    !cfg_req |=> !cfg_ack_r)
    else $error("answer without a request");
  a_unmapped_zero: assert property (
    cfg_req && !cfg_write && !hit_pwr && !hit_smi |=> cfg_rdata_r == RDATA_ZERO)
    else $error("unmapped offset read not zero");
  a_rdata_held: assert property (
    !(cfg_req && !cfg_write) |=> $stable(cfg_rdata_r))
    else $error("read data moved without a read");
  a_upper_zero: assert property (
    cfg_ack_r |-> cfg_rdata_r[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_smi_request: assert property (
    s_set_event |=> ##1 smi_req_r)
    else $error("smi request not raised two cycles after set");
  a_smi_held: assert property (
    smi_lo_r[`GPSS_SMI_EVT_BIT] && !wr_smi_lo |=> smi_lo_r[`GPSS_SMI_EVT_BIT])
    else $error("smi event dropped without a clearing write");
  a_smi_cleared: assert property (
    s_clear_event |=> ##1 !smi_req_r)
    else $error("smi request still raised after clearing write");
  a_flags_write: assert property (
    wr_smi_lo |=> smi_lo_r == $past(cfg_wdata[7:0]))
    else $error("flag byte not stored");
  a_scratch_write: assert property (
    wr_smi_hi |=> smi_hi_r == $past(cfg_wdata[15:8]))
    else $error("scratch byte not stored");
  a_smi_readback: assert property (
    cfg_req && !cfg_write && cfg_addr == SMI_OFF |=> cfg_rdata_r[15:0] == $past(smi_view))
    else $error("smi register not found at its offset");

endmodule
`default_nettype wire

//--- verilog/gpss_pkg.sv
/*
  Types for the graphics power-state register; the SMI register has none here.
  Assumes gpss_regs.svh is on the include path.
*/
`default_nettype none
`include "gpss_regs.svh"

package gpss_pkg;
  typedef enum logic [1:0] {
    GPSS_D0 = `GPSS_PS_D0,
    GPSS_D1 = `GPSS_PS_D1,
    GPSS_D2 = `GPSS_PS_D2,
    GPSS_D3 = `GPSS_PS_D3
  } gpss_pstate_e;
endpackage
`default_nettype wire

//--- verilog/gpss_pm_state.sv
/*
  Power state holder: accepts D0/D3 writes, drops D1/D2, and flags a D3 to D0 exit.
  Assumes write strobes come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gpss_regs.svh"

module gpss_pm_state #(
  parameter int unsigned REINIT_ON_D0 = 1
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Write from config decode
  input  wire logic              wr_en,
  input  wire logic [1:0]        wr_code,
  // State and reinit
  output gpss_pkg::gpss_pstate_e state_r,
  output logic                   reinit_r
);

  generate
    if (REINIT_ON_D0 > 1) begin : g_bad
      $error("REINIT_ON_D0 must be 0 or 1");
    end
  endgenerate

  logic supported;
  assign supported = (wr_code == `GPSS_PS_D0) || (wr_code == `GPSS_PS_D3);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= gpss_pkg::GPSS_D0;
    end else if (wr_en && supported) begin
      state_r <= gpss_pkg::gpss_pstate_e'(wr_code);
    end
  end

  // One-cycle pulse so the controller can be returned to initial values
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reinit_r <= 1'b0;
    end else begin
      reinit_r <= (REINIT_ON_D0 != 0) && wr_en && (state_r == gpss_pkg::GPSS_D3) &&
                  (wr_code == `GPSS_PS_D0);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_exit_d3;
    wr_en && state_r == gpss_pkg::GPSS_D3 && wr_code == `GPSS_PS_D0;
  endsequence

  a_unsupported_kept: assert property (
    wr_en && (wr_code == `GPSS_PS_D1 || wr_code == `GPSS_PS_D2) |=> $stable(state_r))
    else $error("unsupported power state write changed state");
  a_state_accepted: assert property (
    wr_en && (wr_code == `GPSS_PS_D0 || wr_code == `GPSS_PS_D3)
      |=> state_r == $past(wr_code))
    else $error("supported power state write not taken");
  a_reinit_pulse: assert property (
    s_exit_d3 |=> (reinit_r == (REINIT_ON_D0 != 0)) ##1 !reinit_r)
    else $error("reinit pulse wrong on D3 exit");
  a_reinit_cause: assert property (
    reinit_r |-> $past(state_r) == gpss_pkg::GPSS_D3 && state_r == gpss_pkg::GPSS_D0)
    else $error("reinit without D3 to D0 move");

endmodule
`default_nettype wire

//--- verilog/gpss_regs.svh
/*
  Constants for the graphics power-state and software SMI register pair.
  Assumes inclusion by bare name from the package and design modules.
*/
// Function
// - Wake-event status bit 15 of power control/status always reads zero.
// - Wake-event enable bit 8 always reads zero and cannot be set.
// - Power state field 1:0 reads current state; 00 is D0 reset, 11 is D3.
// - Writes of 01 or 10 complete normally but leave the state unchanged.
// - Leaving D3 for D0 may return the graphics controller to initial values.
// - Writing 1 to SMI event bit 0 requests a system management interrupt.
// - SMI register flag bits 7:1 and scratch bits 15:8 are read/write, reset zero.
// - The software SMI register sits at configuration offset E0h-E1h.
`ifndef GPSS_REGS_SVH
`define GPSS_REGS_SVH

// ****************************************************************
// Offsets
// ****************************************************************
`define GPSS_PWR_CS_OFF    8'hD4
`define GPSS_SMI_OFF       8'hE0

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define GPSS_WAKE_STS_BIT  15
`define GPSS_WAKE_EN_BIT   8
`define GPSS_PS_D0         2'h0
`define GPSS_PS_D1         2'h1
`define GPSS_PS_D2         2'h2
`define GPSS_PS_D3         2'h3
`define GPSS_SMI_EVT_BIT   0
`define GPSS_SMI_RESET     16'h0000
`define GPSS_RDATA_RESET   32'h0000_0000
`define GPSS_RSVD_ZERO     6'h00

`endif
